// File: shared/pwrseq_defines.vh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the power-up and hibernate sequencer.
// Assumes: 20 MHz clock, Wishbone classic slave with 32-bit data.
// Notes:   Times are given in their own unit; cycle counts derive from them.
`ifndef PWRSEQ_DEFINES_VH
`define PWRSEQ_DEFINES_VH

// ****************************************
// Clock and timing
// ****************************************
`define PWRSEQ_CLK_HZ          20000000
`define PWRSEQ_T_GATE_US       1000
`define PWRSEQ_T_STEP_US       500
`define PWRSEQ_T_RST_US        1000
`define PWRSEQ_T_BLANK_US      10
`define PWRSEQ_CYC(us)         ((us) * (`PWRSEQ_CLK_HZ / 1000000))
`define PWRSEQ_WAKE_BASE_MS    125

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PWRSEQ_REG_CTRL        8'h00
`define PWRSEQ_REG_STATUS      8'h04
`define PWRSEQ_REG_FAULT       8'h08
`define PWRSEQ_REG_MONSEL      8'h0c

// ****************************************
// Control fields
// ****************************************
`define PWRSEQ_CTRL_HIB        0
`define PWRSEQ_CTRL_PB_EN      1
`define PWRSEQ_CTRL_GATE_12V   2
`define PWRSEQ_CTRL_WAKE_LSB   4
`define PWRSEQ_WAKE_NEVER      3'h7

// ****************************************
// Fault / cause fields (persistent)
// ****************************************
`define PWRSEQ_F_SYS           0
`define PWRSEQ_F_IO            1
`define PWRSEQ_F_ANA           2
`define PWRSEQ_F_CORE          3
`define PWRSEQ_F_CHECK         4
`define PWRSEQ_F_WAKE_TMR      5
`define PWRSEQ_F_WAKE_PB       6
`define PWRSEQ_F_HIB           7

`endif

// File: src/pwrseq_top.v
// Purpose: Timed power-up, supervision and hibernate control of a power manager.
// Assumes: Comparator and button inputs are asynchronous; clk is always-on.
// Notes:   Registers on a Wishbone classic slave; ack is one cycle after request.
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pwrseq_defines.vh"

module pwrseq_top #(
    parameter GATE_DLY  = `PWRSEQ_CYC(`PWRSEQ_T_GATE_US),
    parameter STEP_DLY  = `PWRSEQ_CYC(`PWRSEQ_T_STEP_US),
    parameter RST_DLY   = `PWRSEQ_CYC(`PWRSEQ_T_RST_US),
    parameter BLANK_DLY = `PWRSEQ_CYC(`PWRSEQ_T_BLANK_US),
    parameter WAKE_BASE = `PWRSEQ_WAKE_BASE_MS * (`PWRSEQ_CLK_HZ / 1000)
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        motor_supply_start,
    input  wire        gate_drive_supply_good,
    input  wire        sys_supply_above_4v,
    input  wire        sys_supply_good,
    input  wire        io_supply_good,
    input  wire        analog_3v3_supply_good,
    input  wire        core_logic_supply_good,
    input  wire        push_button_input_n,
    output reg         high_voltage_converter_en,
    output reg         medium_voltage_switcher_en,
    output reg         io_supply_en,
    output reg         analog_3v3_supply_en,
    output reg         core_logic_supply_en,
    output reg         gate_drive_sel_12v,
    output reg         cpu_reset_n,
    output reg  [2:0]  supply_monitor_selector
);

    // ****************************************
    // States
    // ****************************************
    localparam [8:0] S_WAIT_VM  = 9'h001;
    localparam [8:0] S_WAIT_VP  = 9'h002;
    localparam [8:0] S_WAIT_SYS = 9'h004;
    localparam [8:0] S_IO       = 9'h008;
    localparam [8:0] S_ANA      = 9'h010;
    localparam [8:0] S_CORE     = 9'h020;
    localparam [8:0] S_CHECK    = 9'h040;
    localparam [8:0] S_RUN      = 9'h080;
    localparam [8:0] S_HIB      = 9'h100;

    // Declared here because the bus read mux reports the step as status
    reg  [8:0] state;
    reg  [8:0] next_state;

    // Wake index 0..6 maps to 125 ms << index (8 s at 6); 7 never expires
    // Limitation: WAKE_BASE << 6 must still fit in 32 bits
    function [31:0] wake_limit;
        input [2:0] sel;
        begin
            wake_limit = WAKE_BASE << sel;
        end
    endfunction

    // Membership of a one-hot step in a set of steps; shared by all enables
    function in_states;
        input [8:0] st;
        input [8:0] mask;
        begin
            in_states = |(st & mask);
        end
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    reg  [7:0] sync1;
    reg  [7:0] sync2;
    wire [7:0] raw_in = {push_button_input_n, core_logic_supply_good,
                         analog_3v3_supply_good, io_supply_good, sys_supply_good,
                         sys_supply_above_4v, gate_drive_supply_good,
                         motor_supply_start};

    // Two flops per asynchronous comparator or pin.
    // Only sync2 feeds logic; sync1 may be metastable for a cycle.
    // The button bit resets to its idle high level, so that release
    // of reset does not look like a press to the edge detector.
    always @(posedge clk) begin
        if (rst) begin
            sync1 <= 8'h80;
            sync2 <= 8'h80;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end

    // ****************************************
    // Power-good blanking filters
    // ****************************************
    reg [7:0]  filt;
    reg [15:0] blank_cnt [0:7];
    integer    i;

    // A level change is accepted only after it holds for the blanking time.
    // Each input has its own counter, so a glitch on one supply does not
    // restart the filter of another. The filter acts in both directions:
    // a supply is also reported lost only once the loss has persisted,
    // which trades ten microseconds of fault latency for noise immunity.
    // The button shares the filter, which gives it a cheap debounce.
    // Filter outputs reset low except the button, which idles high.
    always @(posedge clk) begin
        if (rst) begin
            filt <= 8'h80;
            for (i = 0; i < 8; i = i + 1)
                blank_cnt[i] <= 16'h0000;
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                if (sync2[i] == filt[i]) begin
                    blank_cnt[i] <= 16'h0000;
                end else if (blank_cnt[i] >= BLANK_DLY[15:0] - 16'h0001) begin
                    filt[i]      <= sync2[i];
                    blank_cnt[i] <= 16'h0000;
                end else begin
                    blank_cnt[i] <= blank_cnt[i] + 16'h0001;
                end
            end
        end
    end

    // Named views of the filtered levels; pg holds the four supervised
    // supplies in the order system, I/O, analog, core (fault bits 3:0).
    // The edge detector sees only filtered levels, never the raw pin.
    wire vm_ok    = filt[0];
    wire vp_ok    = filt[1];
    wire sys_4v   = filt[2];
    wire [3:0] pg = filt[6:3];
    wire all_good = &pg;
    reg  pb_d;
    wire pb_press = pb_d & ~filt[7];      // Falling edge of active-low button

    // ****************************************
    // Register bus
    // ****************************************
    // Map, byte addresses, one 32-bit word each:
    //   CTRL   (0x00) bit 0     hibernate command, self clearing, reads 0
    //                 bit 1     push button function enable
    //                 bit 2     gate drive target 12 V, clear for 15 V
    //                 bits 6:4  wake time index, 7 means never
    //   STATUS (0x04) bits 8:0  one-hot sequencer step
    //                 bits 17:10 filtered levels, motor start in bit 10
    //   FAULT  (0x08) sticky causes, write one to clear
    //                 bits 3:0  system, I/O, analog, core supply lost
    //                 bit 4     power-good check failed
    //                 bits 6:5  woken by timer, woken by button
    //                 bit 7     hibernate entered
    //   MONSEL (0x0c) bits 2:0  monitor channel routed to the converter
    // Only byte lane 0 carries writes. Unmapped addresses read zero and
    // ignore writes. During hibernate the bus still answers, but writes
    // are dropped so that no stale setting survives into the restart.
    // The fault bits, button enable and wake time are kept across hibernate;
    // the last two stay so that the wake sources are not lost.
    reg        hib_cmd;
    reg        pb_en;
    reg  [2:0] wake_sel;
    reg  [7:0] fault;
    reg        fault_clr_req;
    reg  [7:0] fault_clr_mask;
    wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr     = wb_req & wb_we_i & wb_sel_i[0];

    // Single-cycle ack; gate target and monitor select return to defaults in hibernate.
    // A request is taken on the edge where cyc and stb are high and ack is
    // low; ack follows one cycle later with the read data beside it, and
    // masking by ack keeps a request that is still held from being taken
    // twice.
    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o                <= 1'b0;
            wb_dat_o                <= 32'h0000_0000;
            hib_cmd                 <= 1'b0;
            pb_en                   <= 1'b0;
            wake_sel                <= `PWRSEQ_WAKE_NEVER;
            gate_drive_sel_12v      <= 1'b0;
            supply_monitor_selector <= 3'h0;
            fault_clr_req           <= 1'b0;
            fault_clr_mask          <= 8'h00;
        end else begin
            wb_ack_o      <= wb_req;
            fault_clr_req <= 1'b0;
            hib_cmd       <= 1'b0;
            if (state == S_HIB) begin
                // Configuration reverts; wake setup kept until wake
                gate_drive_sel_12v      <= 1'b0;
                supply_monitor_selector <= 3'h0;
            end else if (wr) begin
                case (wb_adr_i)
                    `PWRSEQ_REG_CTRL: begin
                        hib_cmd            <= wb_dat_i[`PWRSEQ_CTRL_HIB];
                        pb_en              <= wb_dat_i[`PWRSEQ_CTRL_PB_EN];
                        gate_drive_sel_12v <= wb_dat_i[`PWRSEQ_CTRL_GATE_12V];
                        wake_sel           <= wb_dat_i[`PWRSEQ_CTRL_WAKE_LSB +: 3];
                    end
                    `PWRSEQ_REG_FAULT: begin
                        fault_clr_req  <= 1'b1;
                        fault_clr_mask <= wb_dat_i[7:0];
                    end
                    `PWRSEQ_REG_MONSEL: supply_monitor_selector <= wb_dat_i[2:0];
                    default: ;
                endcase
            end
            // Read mux; unmapped addresses read zero
            case (wb_adr_i)
                `PWRSEQ_REG_CTRL:   wb_dat_o <= {25'h0, wake_sel, 1'b0,
                                                 gate_drive_sel_12v, pb_en, 1'b0};
                `PWRSEQ_REG_STATUS: wb_dat_o <= {14'h0, filt, 1'b0, state};
                `PWRSEQ_REG_FAULT:  wb_dat_o <= {24'h0, fault};
                `PWRSEQ_REG_MONSEL: wb_dat_o <= {29'h0, supply_monitor_selector};
                default:            wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Each timed step clears cnt on entry and leaves once cnt reaches its
    // delay minus one, so a delay parameter of N lasts N whole clocks.
    // Steps that wait on a comparator restart the count while the level
    // is low, so a supply that dips during its hold restarts the hold.
    // The check step doubles as the reset delay: while any supervised
    // supply is not good the count stays at zero and reset is held.
    // Hazard: the filtered levels lag the pins by two flops plus the
    // blanking time. A step delay shorter than that lag sees the core
    // supply as not yet good; this is logged as a failed check and then
    // waited out, never skipped.
    // Hibernate keeps the count running for the wake timer only.
    reg [31:0] cnt;
    reg        cnt_clr;
    reg [7:0]  fault_set;
    wire       wake_tmr = (wake_sel != `PWRSEQ_WAKE_NEVER) &&
                          (cnt >= wake_limit(wake_sel) - 32'h1);
    wire       go_hib   = hib_cmd | (pb_en & pb_press);

    // Next-state decode; every timed step counts whole clk cycles.
    // Hibernate entry is checked before the supply faults in the run
    // step, since the shut-down it starts removes the supplies anyway.
    // Any code that is not one-hot falls back to the first step.
    always @* begin
        next_state = state;
        cnt_clr    = 1'b0;
        fault_set  = 8'h00;
        case (state)
            S_WAIT_VM:  if (vm_ok) begin
                            next_state = S_WAIT_VP;
                            cnt_clr    = 1'b1;
                        end
            S_WAIT_VP:  if (!vp_ok) begin
                            cnt_clr = 1'b1;
                        end else if (cnt >= GATE_DLY - 1) begin
                            next_state = S_WAIT_SYS;
                            cnt_clr    = 1'b1;
                        end
            S_WAIT_SYS: if (!sys_4v) begin
                            cnt_clr = 1'b1;
                        end else if (cnt >= STEP_DLY - 1) begin
                            next_state = S_IO;
                            cnt_clr    = 1'b1;
                        end
            S_IO:       if (cnt >= STEP_DLY - 1) begin
                            next_state = S_ANA;
                            cnt_clr    = 1'b1;
                        end
            S_ANA:      if (cnt >= STEP_DLY - 1) begin
                            next_state = S_CORE;
                            cnt_clr    = 1'b1;
                        end
            S_CORE:     if (cnt >= STEP_DLY - 1) begin
                            next_state = S_CHECK;
                            cnt_clr    = 1'b1;
                            if (!all_good)
                                fault_set[`PWRSEQ_F_CHECK] = 1'b1;
                        end
            S_CHECK:    if (!all_good) begin
                            cnt_clr = 1'b1;
                        end else if (cnt >= RST_DLY - 1) begin
                            next_state = S_RUN;
                            cnt_clr    = 1'b1;
                        end
            S_RUN:      if (go_hib) begin
                            next_state = S_HIB;
                            cnt_clr    = 1'b1;
                            fault_set[`PWRSEQ_F_HIB] = 1'b1;
                        end else if (!all_good) begin
                            next_state = S_CHECK;
                            cnt_clr    = 1'b1;
                            fault_set[3:0] = ~pg;
                        end
            S_HIB:      if (wake_tmr) begin
                            next_state = S_WAIT_VM;
                            fault_set[`PWRSEQ_F_WAKE_TMR] = 1'b1;
                        end else if (pb_en && pb_press) begin
                            next_state = S_WAIT_VM;
                            fault_set[`PWRSEQ_F_WAKE_PB] = 1'b1;
                        end
            default:    next_state = S_WAIT_VM;
        endcase
    end

    // ****************************************
    // Step register, counter and outputs
    // ****************************************
    // State, delay counter, persistent status and registered outputs.
    // Outputs are decoded from next_state so that each enable is a flop
    // that changes on the same edge as the step it belongs to.
    always @(posedge clk) begin
        if (rst) begin
            state                      <= S_WAIT_VM;
            cnt                        <= 32'h0000_0000;
            fault                      <= 8'h00;
            pb_d                       <= 1'b1;
            high_voltage_converter_en  <= 1'b0;
            medium_voltage_switcher_en <= 1'b0;
            io_supply_en               <= 1'b0;
            analog_3v3_supply_en       <= 1'b0;
            core_logic_supply_en       <= 1'b0;
            cpu_reset_n                <= 1'b0;
        end else begin
            state <= next_state;
            pb_d  <= filt[7];
            cnt   <= (cnt_clr || next_state != state) ? 32'h0 : cnt + 32'h1;
            // New events win over a same-cycle software clear
            fault <= (fault & ~(fault_clr_req ? fault_clr_mask : 8'h00))
                     | fault_set;
            // All enables drop together on hibernate entry
            high_voltage_converter_en  <= ~in_states(next_state, S_WAIT_VM | S_HIB);
            medium_voltage_switcher_en <= ~in_states(next_state, S_WAIT_VM | S_WAIT_VP | S_HIB);
            io_supply_en               <= in_states(next_state, S_IO | S_ANA | S_CORE
                                                              | S_CHECK | S_RUN);
            analog_3v3_supply_en       <= in_states(next_state, S_ANA | S_CORE
                                                              | S_CHECK | S_RUN);
            core_logic_supply_en       <= in_states(next_state, S_CORE | S_CHECK | S_RUN);
            cpu_reset_n                <= (next_state == S_RUN);
        end
    end

endmodule // pwrseq_top

// File: dv/pwrseq_chk.sv
// Purpose: Concurrent checks on the sequencer's ports.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Delay depths follow the parameters handed on by the bind.
`timescale 1ns/1ps
module pwrseq_chk #(
    parameter GATE_DLY = 8,
    parameter STEP_DLY = 4,
    parameter RST_DLY  = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_ack_o,
    input wire logic motor_supply_start,
    input wire logic sys_supply_good,
    input wire logic io_supply_good,
    input wire logic analog_3v3_supply_good,
    input wire logic core_logic_supply_good,
    input wire logic high_voltage_converter_en,
    input wire logic medium_voltage_switcher_en,
    input wire logic io_supply_en,
    input wire logic analog_3v3_supply_en,
    input wire logic core_logic_supply_en,
    input wire logic gate_drive_sel_12v,
    input wire logic cpu_reset_n
);
    // ****************************************
    // Sequencing and supervision properties
    // ****************************************
    localparam int REL = STEP_DLY + RST_DLY;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_hv_after_motor: assert property (
        $rose(high_voltage_converter_en) |-> $past(motor_supply_start, 2))
        else $error("converter enabled without motor supply");
    a_mv_gate_wait: assert property (
        $rose(medium_voltage_switcher_en) |-> $past(high_voltage_converter_en, GATE_DLY))
        else $error("switcher enabled too early");
    a_core_step: assert property (
        $rose(core_logic_supply_en) |-> analog_3v3_supply_en && $past(analog_3v3_supply_en, STEP_DLY))
        else $error("core regulator step too short");
    a_release_good: assert property (
        $rose(cpu_reset_n) |-> sys_supply_good && io_supply_good
            && analog_3v3_supply_good && core_logic_supply_good)
        else $error("reset released with a supply not good");
    a_release_delay: assert property (
        $rose(cpu_reset_n) |-> $past(core_logic_supply_en, REL))
        else $error("reset released before check and delay");
    // Filtered inputs lag the pins, so a held fault gets a bounded window
    a_fault_reset: assert property (
        (cpu_reset_n && !core_logic_supply_good) [*4] |-> ##[1:10] !cpu_reset_n)
        else $error("held supply fault did not reset processor");
    a_all_off: assert property (
        !high_voltage_converter_en && !$past(high_voltage_converter_en) |-> !cpu_reset_n
            && !medium_voltage_switcher_en && !io_supply_en && !core_logic_supply_en)
        else $error("regulator left on while converter off");
    a_gate_default: assert property (
        $rose(high_voltage_converter_en) |-> !gate_drive_sel_12v)
        else $error("startup without default gate target");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    c_release: cover property ($rose(cpu_reset_n));
    c_hibernate: cover property ($fell(high_voltage_converter_en));
    c_fault: cover property ($fell(cpu_reset_n) && core_logic_supply_en);
endmodule // pwrseq_chk

bind pwrseq_top pwrseq_chk #(.GATE_DLY(GATE_DLY), .STEP_DLY(STEP_DLY), .RST_DLY(RST_DLY)) u_chk (
    .clk(clk), .rst(rst), .wb_ack_o(wb_ack_o), .motor_supply_start(motor_supply_start),
    .sys_supply_good(sys_supply_good), .io_supply_good(io_supply_good),
    .analog_3v3_supply_good(analog_3v3_supply_good),
    .core_logic_supply_good(core_logic_supply_good),
    .high_voltage_converter_en(high_voltage_converter_en),
    .medium_voltage_switcher_en(medium_voltage_switcher_en), .io_supply_en(io_supply_en),
    .analog_3v3_supply_en(analog_3v3_supply_en), .core_logic_supply_en(core_logic_supply_en),
    .gate_drive_sel_12v(gate_drive_sel_12v), .cpu_reset_n(cpu_reset_n));

// File: dv/pwrseq_supply_model.sv
// Purpose: Behavioural supplies and comparators facing the sequencer.
// Assumes: Each supply comes good three cycles after its enable.
// Notes:   core_kill pulls the core good low to inject a fault.
`timescale 1ns/1ps
module pwrseq_supply_model (
    input  wire logic       clk,
    input  wire logic       motor_on,
    input  wire logic [4:0] en,
    input  wire logic       core_kill,
    output logic            motor_start,
    output logic [4:0]      good
);
    // ****************************************
    // Supply ramp
    // ****************************************
    logic [4:0] d1, d2, d3;
    // A supply never answers in the cycle it is enabled, and discharges when off
    always @(posedge clk) begin
        d1 <= en;
        d2 <= d1;
        d3 <= d2;
    end
    assign motor_start = motor_on;
    assign good = d3 & {~core_kill, 4'hf};
endmodule // pwrseq_supply_model

// File: dv/tb_pwrseq_top.sv
// Purpose: Self-checking bench for the power-up and hibernate sequencer.
// Assumes: Small delay parameters so a full sequence takes tens of cycles.
// Notes:   Supplies come from the behavioural model; the bench drives the bus.
`timescale 1ns/1ps
module tb_pwrseq_top;
    logic        clk, rst, cyc, stb, we, motor_on, core_kill, button_n;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, q;
    wire  [31:0] rdat;
    wire         ack, hv, mv, io, ana, core, sel12, rstn, motor_start;
    wire  [2:0]  monsel;
    wire  [4:0]  good;
    int          fails, tests_run, n;
    pwrseq_top #(.GATE_DLY(8), .STEP_DLY(4), .RST_DLY(8), .BLANK_DLY(2), .WAKE_BASE(16)) dut (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .motor_supply_start(motor_start), .gate_drive_supply_good(good[0]),
        .sys_supply_above_4v(good[1]), .sys_supply_good(good[1]), .io_supply_good(good[2]),
        .analog_3v3_supply_good(good[3]), .core_logic_supply_good(good[4]),
        .push_button_input_n(button_n), .high_voltage_converter_en(hv),
        .medium_voltage_switcher_en(mv), .io_supply_en(io), .analog_3v3_supply_en(ana),
        .core_logic_supply_en(core), .gate_drive_sel_12v(sel12), .cpu_reset_n(rstn),
        .supply_monitor_selector(monsel));
    pwrseq_supply_model model (.clk(clk), .motor_on(motor_on), .en({core, ana, io, mv, hv}),
        .core_kill(core_kill), .motor_start(motor_start), .good(good));
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until ack is sampled high; released only after that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask
    // Bounded wait for cpu_reset_n (k=0) or converter enable (k=1) to reach v; n holds the cycles
    task automatic wait_sig(input int k, input logic v);
        for (n = 0; n < 600 && ((k == 1) ? hv : rstn) !== v; n++) @(posedge clk);
    endtask
    task automatic press;
        @(posedge clk);
        button_n <= 1'b0;
        repeat (8) @(posedge clk);
        button_n <= 1'b1;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Watchdog: the whole sequence needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish;
    end
    initial begin
        {cyc, stb, we, adr, wdat, motor_on, core_kill, button_n} = {45'h0, 1'b1};
        sel = 4'hf;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h70, "ctrl reset");
        rd(8'h10, 32'h0, "unmapped read");
        check("outputs reset", {hv, mv, io, ana, core, sel12, rstn, monsel}, 0);
        $display("test reset done");
        motor_on <= 1'b1;
        wait_sig(0, 1'b1);
        check("enables on", {hv, mv, io, ana, core, sel12}, 6'b111110);
        rd(8'h04, 32'h3fc80, "status run");
        rd(8'h08, 32'h10, "check failed");
        $display("test power up done");
        wb(1'b1, 8'h00, 32'h74);
        rd(8'h00, 32'h74, "ctrl write");
        check("gate 12v", sel12, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'h0c, i);
            rd(8'h0c, i, "monsel reg");
            check("monsel port", monsel, i);
        end
        sel <= 4'h0;
        wb(1'b1, 8'h0c, 32'h0);
        sel <= 4'hf;
        check("monsel lane 0", monsel, 3'h7);
        $display("test registers done");
        @(posedge clk);
        core_kill <= 1'b1;
        @(posedge clk);
        core_kill <= 1'b0;
        repeat (12) @(posedge clk);
        check("glitch ignored", rstn, 1'b1);
        core_kill <= 1'b1;
        wait_sig(0, 1'b0);
        rd(8'h08, 32'h18, "core fault");
        core_kill <= 1'b0;
        wait_sig(0, 1'b1);
        check("fault hold", n >= 8, 1'b1);
        $display("test fault done");
        wb(1'b1, 8'h00, 32'h01);
        wait_sig(1, 1'b0);
        check("hibernate off", {hv, mv, io, ana, core, rstn}, 0);
        wait_sig(1, 1'b1);
        check("wake timer", n >= 16, 1'b1);
        wait_sig(0, 1'b1);
        rd(8'h08, 32'hb8, "faults kept");
        rd(8'h0c, 32'h0, "monsel default");
        check("gate default", sel12, 1'b0);
        wb(1'b1, 8'h08, 32'hff);
        rd(8'h08, 32'h0, "fault clear");
        $display("test timer hibernate done");
        wb(1'b1, 8'h00, 32'h72);
        press;
        wait_sig(1, 1'b0);
        repeat (60) @(posedge clk);
        check("never wake", {hv, rstn}, 0);
        press;
        wait_sig(0, 1'b1);
        rd(8'h08, 32'hd0, "button wake");
        $display("test button done");
        tally_and_finish;
    end
endmodule // tb_pwrseq_top
